// ===== design/exec_pkg.sv
// Purpose: constants, types and decode helpers for the return and jump executor
// Assumes: 8-bit core, 16-bit program counter, stack held in the register file
// Notes: flag byte layout is C Z S V D H fast-status bank from bit 7 down
package exec_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int CNT_W = 4;
   // register port map
   localparam logic [7:0] FLAGS_ADDR = 8'hD5;
   localparam logic [7:0] STACK_PTR_ADDR = 8'hD9;
   localparam logic [7:0] FVP_HI_ADDR = 8'hDA;
   localparam logic [7:0] FVP_LO_ADDR = 8'hDB;
   localparam logic [7:0] SYS_MODE_ADDR = 8'hDE;
   // flag and mode bit positions
   localparam int FLAG_C = 7;
   localparam int FLAG_Z = 6;
   localparam int FLAG_S = 5;
   localparam int FLAG_V = 4;
   localparam int FSTAT_BIT = 1;
   localparam int GIE_BIT = 0;
   localparam logic [7:0] FSTAT_MASK = 8'h02;
   // opcodes
   localparam logic [7:0] OPC_RET = 8'hBF;
   localparam logic [7:0] OPC_JUMP_PAIR = 8'h30;
   localparam logic [3:0] OPC_JUMP_COND = 4'hD;
   // instruction lengths in clock cycles, fetch to next fetch
   localparam logic [3:0] CYC_RET_NORM = 4'hA;
   localparam logic [3:0] CYC_RET_FAST = 4'h6;
   localparam logic [3:0] CYC_JUMP_COND = 4'h8;
   localparam logic [3:0] CYC_JUMP_PAIR = 4'h8;
   // reset values
   localparam logic [15:0] PC_RESET = 16'h0100;
   localparam logic [15:0] FVP_RESET = 16'h0000;
   localparam logic [7:0] SP_RESET = 8'hC0;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] SYS_MODE_RESET = 8'h00;
   // steps and masks
   localparam logic [15:0] PC_STEP1 = 16'h0001;
   localparam logic [15:0] PC_STEP2 = 16'h0002;
   localparam logic [15:0] PC_STEP3 = 16'h0003;
   localparam logic [7:0] SP_STEP1 = 8'h01;
   localparam logic [7:0] SP_STEP2 = 8'h02;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [7:0] REG_PAGE = 8'h00;
   localparam logic [7:0] PAIR_EVEN_MASK = 8'hFE;
   localparam logic [7:0] PAIR_ODD_BIT = 8'h01;
   localparam logic SPACE_PROG = 1'b0;
   localparam logic SPACE_REG = 1'b1;

   typedef enum logic [2:0] {
      S_FETCH = 3'h0,
      S_DECODE = 3'h1,
      S_RD1 = 3'h3,
      S_RD2 = 3'h2,
      S_RD3 = 3'h6,
      S_PACE = 3'h7
   } exec_state_t;

   typedef enum logic [1:0] {
      K_NONE = 2'h0,
      K_RET = 2'h1,
      K_JCOND = 2'h3,
      K_JPAIR = 2'h2
   } op_kind_t;

   function automatic op_kind_t op_kind(input logic [7:0] opc);
      op_kind_t k;
      k = K_NONE;
      if (opc == OPC_RET) begin
         k = K_RET;
      end else if (opc == OPC_JUMP_PAIR) begin
         k = K_JPAIR;
      end else if (opc[3:0] == OPC_JUMP_COND) begin
         k = K_JCOND;
      end
      return k;
   endfunction

   // upper half of the code set is the inverse of the lower half
   function automatic logic cond_true(input logic [3:0] code, input logic [7:0] fl);
      logic r;
      r = 1'b0;
      unique case (code[2:0])
         3'h0: r = 1'b0;
         3'h1: r = fl[FLAG_S] ^ fl[FLAG_V];
         3'h2: r = fl[FLAG_Z] | (fl[FLAG_S] ^ fl[FLAG_V]);
         3'h3: r = fl[FLAG_C] | fl[FLAG_Z];
         3'h4: r = fl[FLAG_S];
         3'h5: r = fl[FLAG_V];
         3'h6: r = fl[FLAG_Z];
         3'h7: r = fl[FLAG_C];
      endcase
      return r ^ code[3];
   endfunction
endpackage

// ===== design/mem_req_if.sv
// Purpose: read request path from the executor to its memory port
// Assumes: one request per cycle at most
// Notes: data is the memory's answer in the cycle after the request
`timescale 1ns/10ps
`default_nettype none
interface mem_req_if;
   logic req;
   logic space;
   logic [15:0] addr;
   logic [7:0] data;
   modport core (output req, output space, output addr, input data);
   modport port (input req, input space, input addr, output data);
endinterface
`default_nettype wire

// ===== design/mem_port.sv
// Purpose: registers read requests onto the memory pins
// Assumes: memory answers combinationally while the strobe is high
// Notes: memory runs on the core clock, so its data needs no synchroniser
`timescale 1ns/10ps
`default_nettype none
module mem_port (
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // request side
   mem_req_if.port bus,
   // memory pins
   output logic mem_rd_out,
   output logic mem_space_out,
   output logic [exec_pkg::ADDR_W-1:0] mem_addr_out,
   input wire logic [exec_pkg::DATA_W-1:0] mem_data_in
);
   import exec_pkg::*;

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mem_rd_out <= 1'b0;
         mem_space_out <= SPACE_PROG;
         mem_addr_out <= PC_RESET;
      end else begin
         mem_rd_out <= bus.req;
         if (bus.req) begin
            mem_space_out <= bus.space;
            mem_addr_out <= bus.addr;
         end
      end
   end

   assign bus.data = mem_data_in;

   chk_rd_follow: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      bus.req |=> mem_rd_out && mem_addr_out == $past(bus.addr))
      else $error("read strobe does not follow request");
endmodule
`default_nettype wire

// ===== design/return_from_interrupt_jump_exec.sv
// Purpose: executes interrupt return and jump instructions of an 8-bit core
// Assumes: memory answers one cycle after a request; fast_irq_in from core logic
// Notes: an instruction lasts from its fetch request to the next fetch request
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module return_from_interrupt_jump_exec (
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [exec_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [exec_pkg::DATA_W-1:0] reg_rdata_out,
   // memory read port
   output logic mem_rd_out,
   output logic mem_space_out,
   output logic [exec_pkg::ADDR_W-1:0] mem_addr_out,
   input wire logic [exec_pkg::DATA_W-1:0] mem_data_in,
   // interrupt entry and status
   input wire logic fast_irq_in,
   output logic fast_irq_ack_out,
   output logic illegal_op_out,
   output logic gie_out,
   output logic [exec_pkg::ADDR_W-1:0] pc_out
);
   import exec_pkg::*;

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);

   mem_req_if mbus ();

   exec_state_t state_ff;
   exec_state_t nxt_state;
   op_kind_t kind_ff;
   op_kind_t nxt_kind;
   logic [15:0] pc_ff;
   logic [15:0] fvp_ff;
   logic [7:0] flags_ff;
   logic [7:0] shadow_ff;
   logic [7:0] sp_ff;
   logic [7:0] sys_ff;
   logic [7:0] hi_ff;
   logic [7:0] pair_ff;
   logic [3:0] code_ff;
   logic [3:0] cnt_ff;
   logic [3:0] len_ff;
   logic [3:0] nxt_len;
   logic illegal_ff;
   logic ack_ff;
   logic [7:0] rdata_ff;
   logic [7:0] rdat;
   logic [7:0] sp_add1;
   logic enter_irq;
   logic at_decode;
   logic fast_ret;
   logic pop_flags;
   logic ret_done;
   logic cond_hit;
   logic wr_flags;

   function automatic logic [15:0] reg_addr(input logic [7:0] a);
      return {REG_PAGE, a};
   endfunction

   function automatic logic [15:0] pc_add(input logic [15:0] pc, input logic [15:0] step);
      return pc + step;
   endfunction

   mem_port u_mem_port (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .bus(mbus.port),
      .mem_rd_out(mem_rd_out),
      .mem_space_out(mem_space_out),
      .mem_addr_out(mem_addr_out),
      .mem_data_in(mem_data_in)
   );

   assign rdat = mbus.data;
   assign sp_add1 = sp_ff + SP_STEP1;
   assign at_decode = state_ff == S_DECODE;
   // entry only between instructions, so no instruction is ever cut in half
   assign enter_irq = (state_ff == S_FETCH) && fast_irq_in && sys_ff[GIE_BIT];
   assign fast_ret = at_decode && (op_kind(rdat) == K_RET) && flags_ff[FSTAT_BIT];
   assign pop_flags = (state_ff == S_RD1) && (kind_ff == K_RET);
   assign ret_done = (state_ff == S_RD3) && (kind_ff == K_RET);
   assign cond_hit = cond_true(code_ff, flags_ff);
   assign wr_flags = reg_wr_in && (reg_addr_in == FLAGS_ADDR);

   // sequencing and memory requests
   always_comb begin
      nxt_state = state_ff;
      nxt_kind = kind_ff;
      nxt_len = len_ff;
      mbus.req = 1'b0;
      mbus.space = SPACE_PROG;
      mbus.addr = pc_ff;
      unique case (state_ff)
         S_FETCH: begin
            if (!enter_irq) begin
               mbus.req = 1'b1;
               nxt_state = S_DECODE;
            end
         end
         S_DECODE: begin
            nxt_kind = op_kind(rdat);
            unique case (op_kind(rdat))
               K_RET: begin
                  if (flags_ff[FSTAT_BIT]) begin
                     nxt_len = CYC_RET_FAST;
                     nxt_state = S_PACE;
                  end else begin
                     nxt_len = CYC_RET_NORM;
                     mbus.req = 1'b1;
                     mbus.space = SPACE_REG;
                     mbus.addr = reg_addr(sp_ff);
                     nxt_state = S_RD1;
                  end
               end
               K_JCOND: begin
                  nxt_len = CYC_JUMP_COND;
                  mbus.req = 1'b1;
                  mbus.addr = pc_add(pc_ff, PC_STEP1);
                  nxt_state = S_RD1;
               end
               K_JPAIR: begin
                  nxt_len = CYC_JUMP_PAIR;
                  mbus.req = 1'b1;
                  mbus.addr = pc_add(pc_ff, PC_STEP1);
                  nxt_state = S_RD1;
               end
               K_NONE: begin
                  nxt_state = S_FETCH;
               end
            endcase
         end
         S_RD1: begin
            mbus.req = 1'b1;
            nxt_state = S_RD2;
            unique case (kind_ff)
               K_RET: begin
                  mbus.space = SPACE_REG;
                  mbus.addr = reg_addr(sp_add1);
               end
               K_JCOND: begin
                  mbus.addr = pc_add(pc_ff, PC_STEP2);
               end
               K_JPAIR: begin
                  mbus.space = SPACE_REG;
                  mbus.addr = reg_addr(rdat & PAIR_EVEN_MASK);
               end
               K_NONE: begin
                  mbus.req = 1'b0;
                  nxt_state = S_FETCH;
               end
            endcase
         end
         S_RD2: begin
            unique case (kind_ff)
               K_RET: begin
                  mbus.req = 1'b1;
                  mbus.space = SPACE_REG;
                  mbus.addr = reg_addr(sp_add1);
                  nxt_state = S_RD3;
               end
               K_JPAIR: begin
                  mbus.req = 1'b1;
                  mbus.space = SPACE_REG;
                  mbus.addr = reg_addr(pair_ff);
                  nxt_state = S_RD3;
               end
               K_JCOND: begin
                  nxt_state = S_PACE;
               end
               K_NONE: begin
                  nxt_state = S_FETCH;
               end
            endcase
         end
         S_RD3: begin
            nxt_state = S_PACE;
         end
         S_PACE: begin
            // padding keeps the documented length even though reads finish early
            if (cnt_ff == len_ff - CNT_ONE) begin
               nxt_state = S_FETCH;
            end
         end
         default: begin
            nxt_state = S_FETCH;
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_ff <= S_FETCH;
         kind_ff <= K_NONE;
         len_ff <= CYC_RET_FAST;
      end else begin
         state_ff <= nxt_state;
         kind_ff <= nxt_kind;
         len_ff <= nxt_len;
      end
   end

   // cycle count, loaded with one in the fetch cycle so it reads one at decode
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_ff <= CNT_ONE;
      end else if (state_ff == S_FETCH) begin
         cnt_ff <= CNT_ONE;
      end else begin
         cnt_ff <= cnt_ff + CNT_ONE;
      end
   end

   // operand capture
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         code_ff <= OPC_JUMP_COND;
         hi_ff <= REG_PAGE;
         pair_ff <= REG_PAGE;
      end else begin
         if (at_decode) begin
            code_ff <= rdat[7:4];
         end
         if ((state_ff == S_RD1) && (kind_ff == K_JCOND)) begin
            hi_ff <= rdat;
         end else if ((state_ff == S_RD2) && (kind_ff != K_JCOND)) begin
            hi_ff <= rdat;
         end
         if ((state_ff == S_RD1) && (kind_ff == K_JPAIR)) begin
            pair_ff <= rdat | PAIR_ODD_BIT;
         end
      end
   end

   // program counter
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pc_ff <= PC_RESET;
      end else if (enter_irq) begin
         pc_ff <= fvp_ff;
      end else if (fast_ret) begin
         pc_ff <= fvp_ff;
      end else if (at_decode && (op_kind(rdat) == K_NONE)) begin
         pc_ff <= pc_add(pc_ff, PC_STEP1);
      end else if ((state_ff == S_RD2) && (kind_ff == K_JCOND)) begin
         pc_ff <= cond_hit ? {hi_ff, rdat} : pc_add(pc_ff, PC_STEP3);
      end else if (state_ff == S_RD3) begin
         pc_ff <= {hi_ff, rdat};
      end
   end

   // fast vector pointer; swaps win over a write; a fast return parks it past its own opcode
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         fvp_ff <= FVP_RESET;
      end else if (enter_irq || fast_ret) begin
         fvp_ff <= fast_ret ? pc_add(pc_ff, PC_STEP1) : pc_ff;
      end else if (reg_wr_in && (reg_addr_in == FVP_HI_ADDR)) begin
         fvp_ff[15:8] <= reg_wdata_in;
      end else if (reg_wr_in && (reg_addr_in == FVP_LO_ADDR)) begin
         fvp_ff[7:0] <= reg_wdata_in;
      end
   end

   // flags: jumps never touch them
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         flags_ff <= FLAGS_RESET;
         shadow_ff <= FLAGS_RESET;
      end else begin
         if (enter_irq) begin
            shadow_ff <= flags_ff;
            flags_ff <= flags_ff | FSTAT_MASK;
         end else if (fast_ret) begin
            flags_ff <= shadow_ff & ~FSTAT_MASK;
         end else if (pop_flags) begin
            flags_ff <= rdat;
         end else if (wr_flags) begin
            flags_ff <= reg_wdata_in;
         end
      end
   end

   // stack pointer
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sp_ff <= SP_RESET;
      end else if (pop_flags) begin
         sp_ff <= sp_add1;
      end else if (ret_done) begin
         sp_ff <= sp_ff + SP_STEP2;
      end else if (reg_wr_in && (reg_addr_in == STACK_PTR_ADDR)) begin
         sp_ff <= reg_wdata_in;
      end
   end

   // system mode: global enable cleared on entry, set by either return
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sys_ff <= SYS_MODE_RESET;
      end else if (enter_irq) begin
         sys_ff[GIE_BIT] <= 1'b0;
      end else if (fast_ret || ret_done) begin
         sys_ff[GIE_BIT] <= 1'b1;
      end else if (reg_wr_in && (reg_addr_in == SYS_MODE_ADDR)) begin
         sys_ff <= reg_wdata_in;
      end
   end

   // event pulses
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         illegal_ff <= 1'b0;
         ack_ff <= 1'b0;
      end else begin
         illegal_ff <= at_decode && (op_kind(rdat) == K_NONE);
         ack_ff <= enter_irq;
      end
   end

   // register reads, answer in the following cycle; unmapped reads give zero
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_ff <= REG_PAGE;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            FLAGS_ADDR: rdata_ff <= flags_ff;
            STACK_PTR_ADDR: rdata_ff <= sp_ff;
            FVP_HI_ADDR: rdata_ff <= fvp_ff[15:8];
            FVP_LO_ADDR: rdata_ff <= fvp_ff[7:0];
            SYS_MODE_ADDR: rdata_ff <= sys_ff;
            default: rdata_ff <= REG_PAGE;
         endcase
      end
   end

   assign reg_rdata_out = rdata_ff;
   assign fast_irq_ack_out = ack_ff;
   assign illegal_op_out = illegal_ff;
   assign gie_out = sys_ff[GIE_BIT];
   assign pc_out = pc_ff;

   chk_ret_path: assert property (at_decode && op_kind(rdat) == K_RET
      |=> (state_ff == S_PACE) == $past(flags_ff[FSTAT_BIT]))
      else $error("return took the wrong path");
   chk_norm_len: assert property ((state_ff == S_FETCH && !enter_irq)
      ##1 (at_decode && op_kind(rdat) == K_RET && !flags_ff[FSTAT_BIT])
      |-> ##9 (state_ff == S_FETCH))
      else $error("normal return length wrong");
   chk_fast_len: assert property ((state_ff == S_FETCH && !enter_irq) ##1 fast_ret
      |-> ##5 (state_ff == S_FETCH))
      else $error("fast return length wrong");
   chk_fast_swap: assert property (fast_ret
      |=> pc_ff == $past(fvp_ff) && fvp_ff == $past(pc_ff) + PC_STEP1)
      else $error("fast return did not swap");
   chk_fast_flags: assert property (fast_ret
      |=> flags_ff == ($past(shadow_ff) & ~FSTAT_MASK) && $stable(sp_ff))
      else $error("fast return flags or stack wrong");
   chk_entry_swap: assert property (enter_irq
      |=> pc_ff == $past(fvp_ff) && flags_ff[FSTAT_BIT] && !gie_out)
      else $error("fast entry wrong");
   chk_gie_set: assert property (fast_ret || ret_done |=> gie_out)
      else $error("return left interrupts off");
   chk_pop_sp: assert property (pop_flags
      |=> sp_ff == $past(sp_add1) ##3 sp_ff == $past(sp_add1, 4) + SP_STEP2)
      else $error("stack pointer steps wrong");
   chk_jump_flags: assert property ((state_ff == S_RD2 && kind_ff == K_JCOND && !wr_flags)
      |=> $stable(flags_ff))
      else $error("jump changed flags");
   chk_cond_miss: assert property ((state_ff == S_RD2 && kind_ff == K_JCOND && !cond_hit)
      |=> pc_ff == $past(pc_ff) + PC_STEP3)
      else $error("untaken jump pc wrong");
   chk_pair_even: assert property ((state_ff == S_RD1 && kind_ff == K_JPAIR)
      |-> !mbus.addr[0] ##1 mbus.addr[0])
      else $error("pair read order wrong");
   chk_pair_len: assert property ((state_ff == S_FETCH && !enter_irq)
      ##1 (at_decode && op_kind(rdat) == K_JPAIR) |-> ##7 (state_ff == S_FETCH))
      else $error("pair jump length wrong");

   cov_fast_ret: cover property (fast_ret ##5 (state_ff == S_FETCH));
   cov_norm_ret: cover property (ret_done);
   cov_cond_taken: cover property (state_ff == S_RD2 && kind_ff == K_JCOND && cond_hit);
   cov_pair_jump: cover property (state_ff == S_RD3 && kind_ff == K_JPAIR);
endmodule
`default_nettype wire

// ===== verif/test_return_from_interrupt_jump_exec.sv
// Purpose: self-checking bench for the return and jump executor
// Assumes: memory answers combinationally from prog and regf arrays
// Notes: fast entry is raised in a known fetch slot so the return address is fixed
`timescale 1ns/10ps
`default_nettype none
module test_return_from_interrupt_jump_exec;
   import exec_pkg::*;
   typedef struct packed {logic [7:0] fl; logic tk;} row_t;
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic fast_irq_in = 1'b0;
   logic [7:0] reg_rdata_out, mem_data_in, mem_val;
   logic mem_rd_out, mem_space_out, fast_irq_ack_out, illegal_op_out, gie_out;
   logic [15:0] mem_addr_out, pc_out, p, tgt;
   logic [7:0] prog [0:65535];
   logic [7:0] regf [0:255];
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int last = 0;
   row_t rows [16];

   return_from_interrupt_jump_exec dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .mem_rd_out(mem_rd_out), .mem_space_out(mem_space_out),
      .mem_addr_out(mem_addr_out), .mem_data_in(mem_data_in), .fast_irq_in(fast_irq_in),
      .fast_irq_ack_out(fast_irq_ack_out), .illegal_op_out(illegal_op_out), .gie_out(gie_out),
      .pc_out(pc_out));

   // outside a strobe the bus shows the inverse so stale data never passes
   assign mem_val = mem_space_out ? regf[mem_addr_out[7:0]] : prog[mem_addr_out];
   assign mem_data_in = mem_rd_out ? mem_val : ~mem_val;

   initial begin
      forever #25 mclk_in = ~mclk_in;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         $display("BAD timeout expected %0d got %0d", 3000, cyc);
         tally_and_finish;
      end
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h got %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      @(posedge mclk_in);
      check(what, {8'h00, exp}, {8'h00, reg_rdata_out});
   endtask

   // gap 0 skips the length check where the previous fetch is not ours
   task automatic fetch(input logic [15:0] a, input int gap);
      int n;
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
      end while (!(mem_rd_out === 1'b1 && mem_space_out === 1'b0 && mem_addr_out === a) && n < 40);
      check("fetch address", a, mem_addr_out);
      if (gap != 0) check("instruction length", gap[15:0], 16'(cyc - last));
      last = cyc;
   endtask

   initial begin
      int n;
      foreach (prog[i]) prog[i] = 8'h00;
      foreach (regf[i]) regf[i] = 8'h00;
      // row index is the condition code; flags in, taken out
      rows = '{'{8'hF0, 1'b0}, '{8'h20, 1'b1}, '{8'h40, 1'b1}, '{8'h00, 1'b0},
               '{8'h20, 1'b1}, '{8'h00, 1'b0}, '{8'h40, 1'b1}, '{8'h80, 1'b1},
               '{8'h00, 1'b1}, '{8'h30, 1'b1}, '{8'h40, 1'b0}, '{8'h80, 1'b0},
               '{8'h00, 1'b1}, '{8'h10, 1'b0}, '{8'h00, 1'b1}, '{8'h80, 1'b0}};
      regf[8'h22] = 8'h12;
      regf[8'h23] = 8'h34;
      regf[8'h70] = 8'hA4;
      regf[8'h71] = 8'h56;
      regf[8'h72] = 8'h78;
      prog[16'h1234] = OPC_RET;
      prog[16'h200A] = OPC_RET;
      repeat (3) @(posedge mclk_in);
      check("pc at reset", PC_RESET, pc_out);
      reset_n_in <= 1'b1;
      rd("flags at reset", FLAGS_ADDR, FLAGS_RESET);
      rd("stack ptr at reset", STACK_PTR_ADDR, SP_RESET);
      wr(FLAGS_ADDR, rows[0].fl);
      p = 16'h0108;
      for (int i = 0; i < 16; i++) begin
         tgt = p + 16'h0010;
         prog[p] = {i[3:0], OPC_JUMP_COND};
         prog[p + 16'h0001] = tgt[15:8];
         prog[p + 16'h0002] = tgt[7:0];
         fetch(p, (i == 0) ? 0 : 8);
         rd("flags after jump", FLAGS_ADDR, rows[i].fl);
         if (i < 15) wr(FLAGS_ADDR, rows[i + 1].fl);
         p = rows[i].tk ? tgt : p + 16'h0003;
      end
      // odd operand: bit 0 must be ignored when picking the pair
      prog[p] = OPC_JUMP_PAIR;
      prog[p + 16'h0001] = 8'h23;
      fetch(p, 8);
      wr(STACK_PTR_ADDR, 8'h70);
      wr(FVP_HI_ADDR, 8'h20);
      fetch(16'h1234, 8);
      fetch(16'h5678, 10);
      fast_irq_in <= 1'b1;
      check("gie after return", 16'h0001, {15'h0000, gie_out});
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
      end while (fast_irq_ack_out !== 1'b1 && n < 20);
      fast_irq_in <= 1'b0;
      check("fast entry ack", 16'h0001, {15'h0000, fast_irq_ack_out});
      fetch(16'h2000, 0);
      rd("flags in service", FLAGS_ADDR, 8'hA6);
      rd("stack ptr in service", STACK_PTR_ADDR, 8'h73);
      rd("vector high", FVP_HI_ADDR, 8'h56);
      rd("vector low", FVP_LO_ADDR, 8'h79);
      wr(FLAGS_ADDR, 8'h13);
      fetch(16'h200A, 0);
      fetch(16'h5679, 6);
      check("gie after fast return", 16'h0001, {15'h0000, gie_out});
      rd("flags restored", FLAGS_ADDR, 8'hA4);
      rd("stack ptr kept", STACK_PTR_ADDR, 8'h73);
      rd("vector high back", FVP_HI_ADDR, 8'h20);
      rd("vector low back", FVP_LO_ADDR, 8'h0B);
      rd("unmapped read", 8'h10, 8'h00);
      @(posedge mclk_in);
      reset_n_in <= 1'b0;
      @(posedge mclk_in);
      @(posedge mclk_in);
      check("pc after reset", PC_RESET, pc_out);
      check("gie after reset", 16'h0000, {15'h0000, gie_out});
      // second release: first fetch must come from the reset pc, then an unknown opcode pulses
      reset_n_in <= 1'b1;
      fetch(PC_RESET, 0);
      @(posedge mclk_in);
      check("illegal pulse", 16'h0001, {15'h0000, illegal_op_out});
      fetch(PC_RESET + 16'h0001, 2);
      tally_and_finish;
   end
endmodule
`default_nettype wire
